// ===== design/sync_unit.sv
// break/sync timing, receive gating and event flags for the single-wire bus
//
// What this block does
// - gate clear: uart receive follows bus at all times, break included.
// - gate set in line mode: uart receive held high until break and sync detected.
// - control bit 6 selects line mode at 0, bit-serial mode at 1.
// - bit-serial read with gate set: rising edge sets break status bit 0.
// - bit-serial read: break timer runs from falling to rising edge.
// - break timer flags compare match and overflow.
// - write mode: gate cleared, compare flag bit 3 times bus release.
// - write mode: break timer still stops on rising edge.
// - bit 7 picks falling or rising edges for the sync timer stop count.
// - bit 5 set: sync timer equal to compare sets flag 3 and interrupt.
// - bit 4 set: each stop condition interrupts; clear: none.
// - bit 3 set: each line-mode start condition interrupts; clear: none.
// - bit 2 enables the whole synchronisation function.
// - bit 1 clears edge counters, self clears after 15 us.
// - bit 0 resets sync logic, self clears after 15 us.
// - sync timer counts on a 5 MHz tick independent of baud.
// - the break falling edge counts as the first falling edge.
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
module sync_unit
	import sync_unit_pkg::*;
#(
	parameter int TIMER_W = 16,
	parameter int CLEAR_CYCLES = SELF_CLEAR_CYC
) (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// avalon-mm slave
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// bus pin and uart
	input wire logic bus_rx_in,
	output logic uart_rx_out,
	output logic sync_irq_out
);
	// the delay counters are 16 bits wide and the timers are read through a 32-bit word
	if (TIMER_W < 8 || TIMER_W > 32 || CLEAR_CYCLES < 1
		|| CLEAR_CYCLES > 65535) begin : g_param_check
		$error("sync_unit: unsupported parameter value");
	end

	typedef enum {S_IDLE, S_COUNT, S_DONE} sync_state_t;

	// ******************************
	// pin synchronisation
	// ******************************
	logic bus_level;
	edge_t bus_edge;
	bus_edge_detect bus_edge_detect_inst (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.pin_in(bus_rx_in),
		.level_out(bus_level),
		.edge_out(bus_edge)
	);

	// ******************************
	// registers
	// ******************************
	logic [10:0] ctrl0;
	logic [7:0] ctrl1;
	logic [ST_W-1:0] status;
	logic [TIMER_W-1:0] sync_timer;
	logic [TIMER_W-1:0] break_timer;
	logic [TIMER_W-1:0] compare;
	logic [TIMER_W-1:0] break_compare;
	logic [15:0] rst_cnt;
	logic [15:0] clr_cnt;
	logic [3:0] tick_cnt;
	logic [3:0] fall_cnt;
	logic [3:0] rise_cnt;
	logic break_run;
	logic frame_seen;
	logic ack;
	sync_state_t state;
	sync_state_t next_state;

	function automatic logic sel(input logic [4:0] a, input logic [4:0] b);
		sel = (a == b);
	endfunction

	wire wr_hit = avs_write_in && !ack;
	wire wr_c0 = wr_hit && sel(avs_address_in, ADDR_CTRL0) && avs_byteenable_in[0];
	wire wr_c0_hi = wr_hit && sel(avs_address_in, ADDR_CTRL0) && avs_byteenable_in[1];
	wire wr_c1 = wr_hit && sel(avs_address_in, ADDR_CTRL1) && avs_byteenable_in[0];
	wire wr_st = wr_hit && sel(avs_address_in, ADDR_STATUS) && avs_byteenable_in[0];
	wire wr_brk = wr_hit && sel(avs_address_in, ADDR_BREAK_TIMER);
	wire wr_cmp = wr_hit && sel(avs_address_in, ADDR_COMPARE);

	// ******************************
	// decoded control
	// ******************************
	wire soft_rst = (rst_cnt != 16'h0000);
	wire edge_clr = (clr_cnt != 16'h0000) || soft_rst;
	wire enabled = ctrl0[C0_ENABLE] && !soft_rst;
	wire bsd_mode = ctrl0[C0_MODE];
	wire gate = ctrl0[C0_GATE];
	wire tick = (tick_cnt == 4'(TICK_DIV - 1));
	wire [3:0] start_cnt = ctrl1[3:0];
	wire [3:0] stop_cnt = ctrl1[7:4];
	// the break falling edge is edge one, so counters hold total edges seen up to 15
	wire [3:0] next_fall = fall_cnt + 4'h1;
	wire [3:0] next_rise = rise_cnt + 4'h1;
	wire start_ev = enabled && !bsd_mode && bus_edge.fall && state == S_IDLE
		&& next_fall == start_cnt;
	wire stop_ev = enabled && state == S_COUNT && (bsd_mode ? bus_edge.rise
		: ctrl0[C0_STOP_RISE] ? (bus_edge.rise && next_rise == stop_cnt)
		: (bus_edge.fall && next_fall == stop_cnt));
	// bit-serial: each pulse restarts the sync timer so compare can time the release
	wire bsd_start_ev = enabled && bsd_mode && bus_edge.fall && state != S_COUNT;
	wire cmp_ev = enabled && ctrl0[C0_CMP_IE] && tick && state == S_COUNT
		&& sync_timer == compare;
	wire brk_rise_ev = enabled && bsd_mode && gate && bus_edge.rise;
	wire brk_cmp_ev = enabled && break_run && break_timer == break_compare
		&& !ctrl0[C0_BRK_ERR_DIS];
	wire brk_ovf_ev = enabled && break_run && tick && (&break_timer)
		&& !ctrl0[C0_BRK_ERR_DIS];
	wire [ST_W-1:0] set_vec = {brk_ovf_ev, brk_cmp_ev, cmp_ev,
		stop_ev && ctrl0[C0_STOP_IE], start_ev && ctrl0[C0_START_IE], brk_rise_ev};

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: if (start_ev || bsd_start_ev) next_state = S_COUNT;
			S_COUNT: if (stop_ev) next_state = S_DONE;
			S_DONE: if (bsd_start_ev) next_state = S_COUNT;
			default: next_state = S_IDLE;
		endcase
		if (edge_clr || !enabled)
			next_state = S_IDLE;
	end

	// ******************************
	// bus slave: one wait state then ack
	// ******************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			ack <= 1'b0;
		else if (ce_in)
			ack <= (avs_read_in || avs_write_in) && !ack;
	end
	assign avs_waitrequest_out = !(ack && ce_in);

	wire [31:0] rd_mux =
		sel(avs_address_in, ADDR_CTRL0) ? {21'h0, ctrl0[10:2], clr_cnt != 16'h0000, soft_rst} :
		sel(avs_address_in, ADDR_CTRL1) ? {24'h0, ctrl1} :
		sel(avs_address_in, ADDR_STATUS) ? {26'h0, status} :
		sel(avs_address_in, ADDR_SYNC_TIMER) ? 32'(sync_timer) :
		sel(avs_address_in, ADDR_BREAK_TIMER) ? 32'(break_timer) :
		sel(avs_address_in, ADDR_COMPARE) ? 32'(compare) : 32'h0000_0000;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			avs_readdata_out <= 32'h0000_0000;
		else if (ce_in && avs_read_in && !ack)
			avs_readdata_out <= rd_mux;
	end

	// ******************************
	// control registers and self-clear delays
	// ******************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl0 <= C0_RESET;
			ctrl1 <= C1_RESET;
			compare <= '0;
			break_compare <= '1;
			rst_cnt <= 16'h0000;
			clr_cnt <= 16'h0000;
		end else if (ce_in) begin
			if (wr_c0)
				ctrl0[7:0] <= avs_writedata_in[7:0] & C0_WMASK[7:0];
			if (wr_c0_hi)
				ctrl0[10:8] <= avs_writedata_in[10:8] & C0_WMASK[10:8];
			if (wr_c1)
				ctrl1 <= avs_writedata_in[7:0];
			if (wr_cmp)
				compare <= avs_writedata_in[TIMER_W-1:0];
			if (wr_brk)
				break_compare <= avs_writedata_in[TIMER_W-1:0];
			if (wr_c0 && avs_writedata_in[C0_SOFT_RESET])
				rst_cnt <= 16'(CLEAR_CYCLES);
			else if (soft_rst)
				rst_cnt <= rst_cnt - 16'h0001;
			if (wr_c0 && avs_writedata_in[C0_EDGE_CLEAR])
				clr_cnt <= 16'(CLEAR_CYCLES);
			else if (clr_cnt != 16'h0000)
				clr_cnt <= clr_cnt - 16'h0001;
		end
	end

	// ******************************
	// status flags: set wins over a write-one clear
	// ******************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in)
			status <= '0;
		else if (ce_in) begin
			if (soft_rst)
				status <= '0;
			else
				status <= (status & ~(wr_st ? avs_writedata_in[ST_W-1:0] : '0)) | set_vec;
		end
	end
	assign sync_irq_out = |status;

	// ******************************
	// sync timer, edge counters, break timer
	// ******************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tick_cnt <= 4'h0;
			fall_cnt <= 4'h0;
			rise_cnt <= 4'h0;
			sync_timer <= '0;
			break_timer <= '0;
			break_run <= 1'b0;
			frame_seen <= 1'b0;
			state <= S_IDLE;
		end else if (ce_in) begin
			tick_cnt <= tick ? 4'h0 : tick_cnt + 4'h1;
			state <= next_state;
			if (edge_clr || !enabled) begin
				fall_cnt <= 4'h0;
				rise_cnt <= 4'h0;
			end else begin
				if (bus_edge.fall && fall_cnt != 4'hf)
					fall_cnt <= next_fall;
				if (bus_edge.rise && rise_cnt != 4'hf)
					rise_cnt <= next_rise;
			end
			if (soft_rst || start_ev || bsd_start_ev)
				sync_timer <= '0;
			else if (state == S_COUNT && tick)
				sync_timer <= sync_timer + 1'b1;
			// rising edge ends every pulse in either bit-serial direction
			if (soft_rst)
				break_run <= 1'b0;
			else if (enabled && bus_edge.fall)
				break_run <= 1'b1;
			else if (bus_edge.rise || brk_ovf_ev)
				break_run <= 1'b0;
			if (soft_rst || (enabled && bus_edge.fall))
				break_timer <= '0;
			else if (break_run && tick)
				break_timer <= break_timer + 1'b1;
			// sync byte is complete once the stop edge of the window is seen
			if (soft_rst || edge_clr || !enabled || bsd_mode)
				frame_seen <= 1'b0;
			else if (stop_ev)
				frame_seen <= 1'b1;
		end
	end

	// ******************************
	// uart receive gating
	// ******************************
	// limitation: in bit-serial mode the gate bit steers interrupts, not the uart
	assign uart_rx_out = (gate && !bsd_mode && enabled && !frame_seen) ? 1'b1 : bus_level;

	// ******************************
	// checks
	// ******************************
	rx_gated_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(gate && !bsd_mode && enabled && state != S_DONE) |-> uart_rx_out)
		else $error("uart receive not held high while gated");
	rx_pass_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(!gate || bsd_mode || !enabled) |-> (uart_rx_out == bus_level))
		else $error("uart receive does not follow the bus");
	mode_sel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		bsd_mode |-> !start_ev)
		else $error("start counted in bit-serial mode");
	rise_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && brk_rise_ev && !soft_rst) |=> status[ST_BREAK])
		else $error("rising edge break flag missed");
	brk_start_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && enabled && bus_edge.fall) |=> (break_run && break_timer == '0))
		else $error("break timer did not start on falling edge");
	brk_cmp_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && enabled && break_run && break_timer == break_compare
		&& !ctrl0[C0_BRK_ERR_DIS]) |=> status[ST_BRK_CMP])
		else $error("break compare flag missed");
	brk_ovf_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && enabled && break_run && tick && (&break_timer)
		&& !ctrl0[C0_BRK_ERR_DIS]) |=> status[ST_BRK_OVF])
		else $error("break overflow flag missed");
	bsd_start_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && bsd_start_ev && !edge_clr) |=> (state == S_COUNT && sync_timer == '0))
		else $error("bit-serial pulse did not restart the sync timer");
	brk_gate_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && !gate && !status[ST_BREAK] && !soft_rst) |=> !status[ST_BREAK])
		else $error("break flag raised with gate clear");
	brk_stop_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && bus_edge.rise && !bus_edge.fall) |=> !break_run)
		else $error("break timer runs past rising edge");
	stop_rise_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ctrl0[C0_STOP_RISE] && !bsd_mode && bus_edge.fall) |-> !stop_ev)
		else $error("falling edge stopped a rising-edge count");
	cmp_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && cmp_ev && !soft_rst) |=> (status[ST_CMP] && sync_irq_out))
		else $error("compare flag or interrupt missed");
	stop_mask_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && stop_ev && !ctrl0[C0_STOP_IE] && !status[ST_STOP]) |=> !status[ST_STOP])
		else $error("masked stop raised a flag");
	start_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && start_ev && ctrl0[C0_START_IE] && !soft_rst) |=> status[ST_START])
		else $error("start flag missed");
	disable_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && !enabled) |=> state == S_IDLE)
		else $error("sync state left idle while disabled");
	clr_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && wr_c0 && avs_writedata_in[C0_EDGE_CLEAR]) |=> (clr_cnt != 16'h0000) [*2])
		else $error("edge clear did not hold");
	edge_clr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && edge_clr) |=> (fall_cnt == 4'h0 && rise_cnt == 4'h0))
		else $error("edge counters not cleared");
	rst_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && wr_c0 && avs_writedata_in[C0_SOFT_RESET]) |=> soft_rst ##1 status == '0)
		else $error("soft reset did not take effect");
	timer_tick_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && !tick && !start_ev && !bsd_start_ev && !soft_rst) |=> $stable(sync_timer))
		else $error("sync timer moved between ticks");
	fall_first_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && enabled && !edge_clr && bus_edge.fall && fall_cnt == 4'h0) |=> fall_cnt == 4'h1)
		else $error("first falling edge not counted as one");
	rd_self_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
		(ce_in && avs_read_in && !ack && sel(avs_address_in, ADDR_CTRL0) && soft_rst)
		|=> avs_readdata_out[C0_SOFT_RESET])
		else $error("running soft reset did not read as one");
endmodule

// ===== design/sync_unit_pkg.sv
// shared constants and types for the bus synchronisation unit
package sync_unit_pkg;
	// ******************************
	// register map (byte addresses)
	// ******************************
	localparam logic [4:0] ADDR_CTRL0 = 5'h00;
	localparam logic [4:0] ADDR_CTRL1 = 5'h04;
	localparam logic [4:0] ADDR_STATUS = 5'h08;
	localparam logic [4:0] ADDR_SYNC_TIMER = 5'h0c;
	localparam logic [4:0] ADDR_BREAK_TIMER = 5'h10;
	localparam logic [4:0] ADDR_COMPARE = 5'h14;
	// ******************************
	// control zero fields
	// ******************************
	localparam int C0_SOFT_RESET = 0;
	localparam int C0_EDGE_CLEAR = 1;
	localparam int C0_ENABLE = 2;
	localparam int C0_START_IE = 3;
	localparam int C0_STOP_IE = 4;
	localparam int C0_CMP_IE = 5;
	localparam int C0_MODE = 6;
	localparam int C0_STOP_RISE = 7;
	localparam int C0_GATE = 8;
	localparam int C0_BRK_ERR_DIS = 10;
	localparam logic [10:0] C0_RESET = 11'h000;
	localparam logic [10:0] C0_WMASK = 11'h5fc;
	// ******************************
	// control one and status fields
	// ******************************
	localparam logic [7:0] C1_RESET = 8'h32;
	localparam int ST_BREAK = 0;
	localparam int ST_START = 1;
	localparam int ST_STOP = 2;
	localparam int ST_CMP = 3;
	localparam int ST_BRK_CMP = 4;
	localparam int ST_BRK_OVF = 5;
	localparam int ST_W = 6;
	// ******************************
	// timing
	// ******************************
	localparam int CLK_HZ = 40_000_000;
	localparam int TICK_HZ = 5_000_000;
	localparam int TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int SELF_CLEAR_NS = 15_000;
	localparam int SELF_CLEAR_CYC = (SELF_CLEAR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	typedef struct packed {
		logic rise;
		logic fall;
	} edge_t;
endpackage

// ===== design/bus_edge_detect.sv
// synchroniser and edge detector for the bus receive pin
`timescale 1ns/100ps
module bus_edge_detect
	import sync_unit_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// pin and result
	input wire logic pin_in,
	output logic level_out,
	output edge_t edge_out
);
	logic meta;
	logic sync;
	logic last;

	// the bus idles high, so all stages reset to one
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta <= 1'b1;
			sync <= 1'b1;
			last <= 1'b1;
		end else if (ce_in) begin
			meta <= pin_in;
			sync <= meta;
			last <= sync;
		end
	end

	assign level_out = sync;
	assign edge_out.rise = ce_in && sync && !last;
	assign edge_out.fall = ce_in && !sync && last;
endmodule

// ===== testbench/bus_node_model.sv
// single-wire bus node model that drives low pulses onto the receive pin
`timescale 1ns/100ps
module bus_node_model (
	// clock
	input wire logic clk_in,
	// bus pin
	output logic bus_out
);
	// ******************************
	// pulse driver
	// ******************************
	// the wire has a pull-up, so a released line reads high
	initial bus_out = 1'b1;
	// every pulse ends with the line released, so a mode change never meets a held bus
	task automatic pulse(input int low_cyc, input int high_cyc);
		@(posedge clk_in);
		bus_out <= 1'b0;
		repeat (low_cyc) @(posedge clk_in);
		bus_out <= 1'b1;
		repeat (high_cyc) @(posedge clk_in);
	endtask
endmodule

// ===== testbench/test_sync_unit.sv
// self-checking bench for the synchronisation unit
`timescale 1ns/100ps
module test_sync_unit;
	import sync_unit_pkg::*;
	localparam int CLR = 20;
	logic clk_in, resetn_in, ce_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic bus_rx_in, uart_rx_out, sync_irq_out;
	logic [4:0] avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, rd;
	logic [3:0] avs_byteenable_in;
	logic [31:0] lin_cfg [3] = '{32'h13c, 32'h004, 32'h038};
	logic [31:0] lin_sta [3] = '{32'h0e, 32'h0, 32'h0};
	int failures = 0;
	int check_count = 0;

	sync_unit #(.TIMER_W(8), .CLEAR_CYCLES(CLR)) sync_unit_inst (.clk_in(clk_in),
		.resetn_in(resetn_in), .ce_in(ce_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.bus_rx_in(bus_rx_in), .uart_rx_out(uart_rx_out), .sync_irq_out(sync_irq_out));
	bus_node_model bus_node_model_inst (.clk_in(clk_in), .bus_out(bus_rx_in));

	// ******************************
	// helpers
	// ******************************
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// entered just after a rising edge; waits for waitrequest low at a rising edge only
	task automatic access(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr_en;
		avs_read_in <= !wr_en;
		do
			@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0);
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge clk_in);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		access(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
		access(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic irqchk(input logic exp);
		check({31'h0, sync_irq_out}, {31'h0, exp});
	endtask
	// break, then pulses; the uart line is sampled in the middle of the break
	task automatic lin_frame(input logic exp_uart);
		fork
			bus_node_model_inst.pulse(400, 40);
			begin
				repeat (200) @(posedge clk_in);
				check({31'h0, uart_rx_out}, {31'h0, exp_uart});
			end
		join
		repeat (3) bus_node_model_inst.pulse(40, 40);
	endtask

	// ******************************
	// tests
	// ******************************
	initial begin
		resetn_in = 1'b0;
		ce_in = 1'b1;
		avs_address_in = 5'h00;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_writedata_in = 32'h0;
		avs_byteenable_in = 4'hf;
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		rdchk(ADDR_CTRL0, 32'h0);
		rdchk(ADDR_CTRL1, {24'h0, C1_RESET});
		rdchk(ADDR_STATUS, 32'h0);
		rdchk(5'h1c, 32'h0);
		irqchk(1'b0);
		wr(ADDR_CTRL0, 32'h7fc);
		rdchk(ADDR_CTRL0, 32'h5fc);
		wr(ADDR_CTRL0, 32'h0);
		$display("test reset_values done");
		for (int b = 0; b < 2; b++) begin
			wr(ADDR_CTRL0, 32'h1 << b);
			access(1'b0, ADDR_CTRL0, 32'h0);
			check({31'h0, rd[b]}, 32'h1);
			repeat (CLR + 10) @(posedge clk_in);
			rdchk(ADDR_CTRL0, 32'h0);
		end
		$display("test self_clear done");
		wr(ADDR_COMPARE, 32'h3);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CTRL0, lin_cfg[i]);
			lin_frame(lin_cfg[i][8]);
			rdchk(ADDR_STATUS, lin_sta[i]);
			irqchk(lin_sta[i] != 32'h0);
			fork
				bus_node_model_inst.pulse(40, 40);
				begin
					repeat (20) @(posedge clk_in);
					check({31'h0, uart_rx_out}, 32'h0);
				end
			join
			wr(ADDR_CTRL0, 32'h1);
			repeat (CLR + 10) @(posedge clk_in);
			rdchk(ADDR_STATUS, 32'h0);
		end
		$display("test line_mode done");
		wr(ADDR_BREAK_TIMER, 32'h5);
		wr(ADDR_CTRL0, 32'h144);
		bus_node_model_inst.pulse(80, 40);
		access(1'b0, ADDR_BREAK_TIMER, 32'h0);
		check({31'h0, rd >= 32'd9 && rd <= 32'd11}, 32'h1);
		rdchk(ADDR_STATUS, 32'h11);
		wr(ADDR_STATUS, 32'h11);
		rdchk(ADDR_STATUS, 32'h0);
		irqchk(1'b0);
		wr(ADDR_COMPARE, 32'h4);
		wr(ADDR_CTRL0, 32'h064);
		bus_node_model_inst.pulse(80, 40);
		access(1'b0, ADDR_STATUS, 32'h0);
		check({31'h0, rd[ST_BREAK]}, 32'h0);
		check({31'h0, rd[ST_CMP]}, 32'h1);
		access(1'b0, ADDR_BREAK_TIMER, 32'h0);
		check({31'h0, rd >= 32'd9 && rd <= 32'd11}, 32'h1);
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_CTRL0, i ? 32'h544 : 32'h144);
			wr(ADDR_STATUS, 32'h3f);
			bus_node_model_inst.pulse(2400, 40);
			access(1'b0, ADDR_STATUS, 32'h0);
			check({31'h0, rd[ST_BRK_OVF]}, {31'h0, i == 0});
		end
		$display("test bit_serial done");
		finish_test();
	end

	initial begin
		repeat (30000) @(posedge clk_in);
		failures++;
		$display("mismatch at %0t: run did not finish", $time);
		finish_test();
	end
endmodule
